// ===== logic/dma_flag_pkg.sv
// Shared constants and types for the DMA channel event flag bank.
package dma_flag_pkg;

    // Number of DMA channels served by the flag bank.
    localparam int NUM_CH   = 3;
    // Flag bits per channel group.
    localparam int GROUP_W  = 4;
    // Width of the whole flag word.
    localparam int FLAG_W   = NUM_CH * GROUP_W;
    // Register bus widths.
    localparam int ADDR_W   = 8;
    localparam int DATA_W   = 32;
    // Unused upper bits of a register word, which read as zero.
    localparam int PAD_W    = DATA_W - FLAG_W;
    // Width of a channel's programmed transfer count.
    localparam int COUNT_W  = 16;

    // Register byte offsets.
    localparam logic [ADDR_W-1:0] STATUS_OFS   = 8'h00;
    localparam logic [ADDR_W-1:0] CLEAR_OFS    = 8'h04;
    localparam logic [ADDR_W-1:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [ADDR_W-1:0] IRQ_MASK_OFS = 8'h0C;

    // Reset value of every flag word.
    localparam logic [FLAG_W-1:0]  FLAGS_RESET = 12'h000;
    // Reset value of the read data register.
    localparam logic [DATA_W-1:0]  DATA_RESET  = 32'h0000_0000;
    // Transfer count at which the half-transfer event is suppressed.
    localparam logic [COUNT_W-1:0] COUNT_ONE   = 16'h0001;

    // Event pulses from one channel's transfer engine.
    typedef struct packed {
        logic error;     // Transfer error on this channel.
        logic half;      // Half of the transfer has been moved.
        logic complete;  // The transfer has ended.
    } ch_event_t;

    // One channel's flag group, highest bit first.
    typedef struct packed {
        logic transfer_error_flag;
        logic half_transfer_flag;
        logic transfer_complete_flag;
        logic channel_any_event_flag;
    } flag_group_t;

    // Reset value of a flag group.
    localparam flag_group_t GROUP_RESET = 4'h0;

    // Whole state of the register bank.
    typedef struct packed {
        logic [DATA_W-1:0] rd_data;     // Read data, valid one cycle.
        logic [FLAG_W-1:0] irq_status;  // Sticky interrupt causes.
        logic [FLAG_W-1:0] irq_mask;    // Interrupt enables.
        logic              irq;         // Interrupt line.
    } bank_state_t;

    // Reset value of the bank state.
    localparam bank_state_t BANK_RESET = '{
        rd_data:    DATA_RESET,
        irq_status: FLAGS_RESET,
        irq_mask:   FLAGS_RESET,
        irq:        1'b0
    };

endpackage

// ===== logic/channel_flag_group.sv
`timescale 1ns/100ps
// Sticky event flags of one DMA channel.
module channel_flag_group (
    input  wire logic                            clock,
    input  wire logic                            sys_rst,
    input  wire logic                            clk_en,
    input  wire dma_flag_pkg::ch_event_t         events,
    input  wire logic [dma_flag_pkg::COUNT_W-1:0] remaining_transfer_count,
    input  wire dma_flag_pkg::flag_group_t       clear_bits,
    output dma_flag_pkg::flag_group_t            flags,
    output dma_flag_pkg::flag_group_t            set_pulses
);

    // Registered flag group and its next value.
    dma_flag_pkg::flag_group_t state_r;
    dma_flag_pkg::flag_group_t state_nxt;
    // Effective clear mask after the global clear is folded in.
    dma_flag_pkg::flag_group_t clr_mask;
    // Half event gated by the transfer count.
    logic                      half_ok;

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic.
    always_comb begin
        half_ok = events.half && (remaining_transfer_count != dma_flag_pkg::COUNT_ONE);
        set_pulses.transfer_error_flag = events.error;
        set_pulses.half_transfer_flag = half_ok;
        set_pulses.transfer_complete_flag = events.complete;
        set_pulses.channel_any_event_flag = events.error || half_ok || events.complete;
        if (clear_bits.channel_any_event_flag) begin
            clr_mask = '1;
        end else begin
            clr_mask = clear_bits;
        end
        state_nxt = (state_r & ~clr_mask) | set_pulses;
    end

    ////////////////////////////////////////////////////////////////////////
    // Flag register; it freezes while the clock enable is low.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= dma_flag_pkg::GROUP_RESET;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    // The flags leave the group straight from the register.
    assign flags = state_r;

endmodule

// ===== logic/dma_event_status_flags.sv
`timescale 1ns/100ps
// Function
// - Four flag bits per channel, reserved above
// - Error event sets sticky error flag
// - Half event sets sticky half flag
// - Complete event sets sticky complete flag
// - Any event but a half event at count one sets channel combined flag
// - Flags read-only, hardware-set, zero after reset
// - Only written ones in clear register clear
// - Zero has no effect; global clears its channel's group
// - Count of one never sets half flag
module dma_event_status_flags (
    input  wire logic                                        clock,
    input  wire logic                                        sys_rst,
    input  wire logic                                        clk_en,
    input  wire logic [dma_flag_pkg::ADDR_W-1:0]             bus_addr,
    input  wire logic [dma_flag_pkg::DATA_W-1:0]             bus_wr_data,
    input  wire logic                                        bus_wr_en,
    input  wire logic                                        bus_rd_en,
    input  wire dma_flag_pkg::ch_event_t [dma_flag_pkg::NUM_CH-1:0] ch_events,
    input  wire logic [dma_flag_pkg::NUM_CH-1:0][dma_flag_pkg::COUNT_W-1:0]
                                                             remaining_transfer_count,
    output logic [dma_flag_pkg::DATA_W-1:0]                  bus_rd_data,
    output logic                                             irq
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations.

    // Whole registered state of the bank.
    dma_flag_pkg::bank_state_t state_r;
    // Next value of the bank state.
    dma_flag_pkg::bank_state_t state_nxt;

    // Flag word as assembled from the channel groups.
    logic [dma_flag_pkg::FLAG_W-1:0] event_status_register;
    // Set pulses of all channels, same layout as the flag word.
    logic [dma_flag_pkg::FLAG_W-1:0] set_vector;
    // Clear bits taken from a write to the clear register.
    logic [dma_flag_pkg::FLAG_W-1:0] event_flag_clear_register;

    // Address decode strobes.
    logic wr_clear;      // Write to the flag clear register.
    logic wr_mask;       // Write to the interrupt mask register.
    logic rd_irq_stat;   // Read of the interrupt status register.

    ////////////////////////////////////////////////////////////////////////
    // Address decode.

    // The event status register is read-only, so a write to its offset
    // decodes to nothing at all. Writes to unmapped offsets are dropped
    // in the same way; the slave never stalls the master.
    always_comb begin
        wr_clear    = bus_wr_en && (bus_addr == dma_flag_pkg::CLEAR_OFS);
        // The mask register is plain read/write.
        wr_mask     = bus_wr_en && (bus_addr == dma_flag_pkg::IRQ_MASK_OFS);
        // Reading the interrupt status clears it.
        rd_irq_stat = bus_rd_en && (bus_addr == dma_flag_pkg::IRQ_STAT_OFS);
    end

    // Only written ones reach the flag groups; a zero bit leaves its
    // flag alone, and the reserved upper data bits are ignored.
    always_comb begin
        if (wr_clear) begin
            event_flag_clear_register = bus_wr_data[dma_flag_pkg::FLAG_W-1:0];
        end else begin
            event_flag_clear_register = dma_flag_pkg::FLAGS_RESET;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel flag groups.

    // One group per channel. Channel 0 sits in the lowest nibble and each
    // following channel one nibble higher. The groups hold the only copy
    // of the flags, so software has no path to set them.
    for (genvar ch = 0; ch < dma_flag_pkg::NUM_CH; ch++) begin : g_ch
        // Flags of this channel.
        dma_flag_pkg::flag_group_t grp_flags;
        // Set pulses of this channel.
        dma_flag_pkg::flag_group_t grp_sets;

        channel_flag_group u_group (
            .clock                    (clock),
            .sys_rst                  (sys_rst),
            .clk_en                   (clk_en),
            .events                   (ch_events[ch]),
            .remaining_transfer_count (remaining_transfer_count[ch]),
            .clear_bits               (event_flag_clear_register[
                                           ch*dma_flag_pkg::GROUP_W +:
                                           dma_flag_pkg::GROUP_W]),
            .flags                    (grp_flags),
            .set_pulses               (grp_sets)
        );

        assign event_status_register[ch*dma_flag_pkg::GROUP_W +:
                                     dma_flag_pkg::GROUP_W] = grp_flags;
        // The interrupt causes share the same layout.
        assign set_vector[ch*dma_flag_pkg::GROUP_W +:
                          dma_flag_pkg::GROUP_W] = grp_sets;
    end

    ////////////////////////////////////////////////////////////////////////
    // Next-state logic of the register bank.

    // All bank state is computed here and registered below. The read data
    // register holds a value only in the cycle after a read strobe and is
    // zero otherwise, so a stale word never lingers on the bus.
    always_comb begin
        // Start from the held state.
        state_nxt = state_r;

        // Read data: zero unless a read is under way.
        state_nxt.rd_data = dma_flag_pkg::DATA_RESET;
        if (bus_rd_en) begin
            unique case (bus_addr)
                dma_flag_pkg::STATUS_OFS: begin
                    state_nxt.rd_data = {{dma_flag_pkg::PAD_W{1'b0}},
                                         event_status_register};
                end
                // The clear register is write-only and reads as zero.
                dma_flag_pkg::CLEAR_OFS: begin
                    state_nxt.rd_data = dma_flag_pkg::DATA_RESET;
                end
                // Sticky interrupt causes as they stand before the clear.
                dma_flag_pkg::IRQ_STAT_OFS: begin
                    state_nxt.rd_data = {{dma_flag_pkg::PAD_W{1'b0}},
                                         state_r.irq_status};
                end
                // Interrupt enables read back as written.
                dma_flag_pkg::IRQ_MASK_OFS: begin
                    state_nxt.rd_data = {{dma_flag_pkg::PAD_W{1'b0}},
                                         state_r.irq_mask};
                end
                // Unmapped offsets answer with zero.
                default: begin
                    state_nxt.rd_data = dma_flag_pkg::DATA_RESET;
                end
            endcase
        end

        // Mask register write; bits above the flag word are dropped.
        if (wr_mask) begin
            state_nxt.irq_mask = bus_wr_data[dma_flag_pkg::FLAG_W-1:0];
        end

        // Interrupt status: a read clears it, but an event arriving in the
        // very cycle of the read is merged in after the clear so that it
        // still raises the line afterwards.
        if (rd_irq_stat) begin
            state_nxt.irq_status = dma_flag_pkg::FLAGS_RESET;
        end
        state_nxt.irq_status = state_nxt.irq_status | set_vector;

        // The line follows the next status and mask, so it comes from a
        // flip-flop yet stays in step with the registers it reflects.
        state_nxt.irq = |(state_nxt.irq_status & state_nxt.irq_mask);
    end

    ////////////////////////////////////////////////////////////////////////
    // State register.

    // Asynchronous reset loads constants only. While the clock enable is
    // low nothing moves, including bus accesses, which are then lost; the
    // master is expected to keep the enable high around its accesses.
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            state_r <= dma_flag_pkg::BANK_RESET;
        end else if (clk_en) begin
            state_r <= state_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs, straight from the state register.

    // Read data of the previous cycle's read strobe.
    assign bus_rd_data = state_r.rd_data;
    // Level interrupt.
    assign irq         = state_r.irq;

endmodule

// ===== test/dma_event_status_flags_sva.sv
`timescale 1ns/100ps
// Port-level checker for the DMA channel event flag bank.
module dma_event_status_flags_sva (
    input wire logic                                                    clock,
    input wire logic                                                    sys_rst,
    input wire logic                                                    clk_en,
    input wire logic [dma_flag_pkg::ADDR_W-1:0]                         bus_addr,
    input wire logic [dma_flag_pkg::DATA_W-1:0]                         bus_wr_data,
    input wire logic                                                    bus_wr_en,
    input wire logic                                                    bus_rd_en,
    input wire dma_flag_pkg::ch_event_t [dma_flag_pkg::NUM_CH-1:0]      ch_events,
    input wire logic [dma_flag_pkg::NUM_CH-1:0][dma_flag_pkg::COUNT_W-1:0]
                                                                        remaining_transfer_count,
    input wire logic [dma_flag_pkg::DATA_W-1:0]                         bus_rd_data,
    input wire logic                                                    irq
);
    // A frozen cycle drops its accesses, so checks pause while the enable is low.
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst || !clk_en);

    // Decoded status reads and clear-register writes.
    wire logic st_rd = bus_rd_en && (bus_addr == dma_flag_pkg::STATUS_OFS);
    wire logic cl_wr = bus_wr_en && (bus_addr == dma_flag_pkg::CLEAR_OFS);

    ////////////////////////////////////////////////////////////////////////////////
    property p_rd_idle; !bus_rd_en |=> bus_rd_data == 32'h0000_0000; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero when idle");
    property p_rsvd; bus_rd_en |=> bus_rd_data[31:12] == 20'h00000; endproperty
    a_rsvd: assert property (p_rsvd) else $error("upper read bits not zero");
    property p_err; ch_events[0].error ##1 st_rd |=> bus_rd_data[3] && bus_rd_data[0]; endproperty
    a_err: assert property (p_err) else $error("error flag not set");
    property p_half;
        (ch_events[1].half && remaining_transfer_count[1] != 16'h0001) ##1 st_rd
            |=> bus_rd_data[6] && bus_rd_data[4];
    endproperty
    a_half: assert property (p_half) else $error("half flag not set");
    property p_cmpl; ch_events[2].complete ##1 st_rd |=> bus_rd_data[9:8] == 2'h3; endproperty
    a_cmpl: assert property (p_cmpl) else $error("complete flag not set");
    property p_clr;
        (cl_wr && bus_wr_data[1] && !ch_events[0].complete) ##1 st_rd |=> !bus_rd_data[1];
    endproperty
    a_clr: assert property (p_clr) else $error("complete flag not cleared");
    property p_gclr;
        (cl_wr && bus_wr_data[0] && ch_events[0] == 3'h0) ##1 st_rd |=> bus_rd_data[3:0] == 4'h0;
    endproperty
    a_gclr: assert property (p_gclr) else $error("channel group not cleared");
    property p_setwin;
        (cl_wr && bus_wr_data[8] && ch_events[2].complete) ##1 st_rd |=> bus_rd_data[9:8] == 2'h3;
    endproperty
    a_setwin: assert property (p_setwin) else $error("event lost against clear");

    // Main scenarios.
    c_one: cover property (ch_events[0].half && remaining_transfer_count[0] == 16'h0001);
    c_win: cover property (cl_wr && ch_events[2].complete);
    c_irq: cover property ($rose(irq));
endmodule

// ===== test/dma_event_status_flags_tb_top.sv
`timescale 1ns/100ps
// Self-checking bench for the DMA channel event flag bank.
`define CHK(got, exp) begin samples_checked++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD t=%0t got %0h want %0h", $time, got, exp); end end
module dma_event_status_flags_tb_top;
    logic                                                   clock;
    logic                                                   sys_rst;
    logic                                                   clk_en;
    logic [dma_flag_pkg::ADDR_W-1:0]                        bus_addr;
    logic [dma_flag_pkg::DATA_W-1:0]                        bus_wr_data;
    logic                                                   bus_wr_en;
    logic                                                   bus_rd_en;
    dma_flag_pkg::ch_event_t [dma_flag_pkg::NUM_CH-1:0]     ch_events;
    logic [dma_flag_pkg::NUM_CH-1:0][dma_flag_pkg::COUNT_W-1:0] counts;
    logic [dma_flag_pkg::DATA_W-1:0]                        bus_rd_data;
    logic                                                   irq;
    int                                                     bad_count;
    int                                                     samples_checked;
    int                                                     cycle_count;

    dma_event_status_flags dut_u (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
        .bus_addr(bus_addr), .bus_wr_data(bus_wr_data), .bus_wr_en(bus_wr_en),
        .bus_rd_en(bus_rd_en), .ch_events(ch_events), .remaining_transfer_count(counts),
        .bus_rd_data(bus_rd_data), .irq(irq));

    // Clock at 125 MHz.
    initial clock = 1'b0;
    always #4 clock = ~clock;

    // A hang costs a mismatch and ends the run.
    always @(posedge clock) begin
        cycle_count++;
        if (cycle_count == 3000) begin
            bad_count++;
            end_of_test();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // One bus cycle; every bus and event input is set each time, so strobes last exactly one cycle.
    task automatic cyc(input logic w, input logic r, input logic [7:0] a,
                       input logic [31:0] d, input logic [8:0] e);
        @(posedge clock);
        bus_wr_en   <= w;
        bus_rd_en   <= r;
        bus_addr    <= a;
        bus_wr_data <= d;
        ch_events   <= e;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        cyc(1'b1, 1'b0, a, d, 9'h000);
    endtask
    // Read data stand only in the cycle after the strobe, so they are looked at there.
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        cyc(1'b0, 1'b1, a, 32'h0, 9'h000);
        cyc(1'b0, 1'b0, a, 32'h0, 9'h000);
        #1 `CHK(bus_rd_data, exp)
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_events;
        logic [31:0] k;
        logic [31:0] grp;
        for (int c = 0; c < 3; c++) begin
            for (int j = 0; j < 3; j++) begin
                k = 32'h1 << j;
                grp = (32'h1 | (k << 1)) << (4 * c);
                cyc(1'b0, 1'b0, 8'h00, 32'h0, 9'(k) << (3 * c));
                rd(dma_flag_pkg::STATUS_OFS, grp);
                wr(dma_flag_pkg::CLEAR_OFS, 32'h0);
                wr(dma_flag_pkg::STATUS_OFS, 32'hFFFF_FFFF);
                rd(dma_flag_pkg::STATUS_OFS, grp);
                wr(dma_flag_pkg::CLEAR_OFS, (k << 1) << (4 * c));
                rd(dma_flag_pkg::STATUS_OFS, 32'h1 << (4 * c));
                wr(dma_flag_pkg::CLEAR_OFS, 32'h1 << (4 * c));
                rd(dma_flag_pkg::STATUS_OFS, 32'h0);
            end
        end
        $display("t_events done");
    endtask

    // A one-item transfer has no half point.
    task automatic t_count_one;
        @(posedge clock) counts[0] <= 16'h0001;
        cyc(1'b0, 1'b0, 8'h00, 32'h0, 9'h002);
        rd(dma_flag_pkg::STATUS_OFS, 32'h0);
        cyc(1'b0, 1'b0, 8'h00, 32'h0, 9'h001);
        rd(dma_flag_pkg::STATUS_OFS, 32'h3);
        wr(dma_flag_pkg::CLEAR_OFS, 32'h1);
        counts[0] <= 16'h0005;
        // A global clear racing a completion must not lose the event.
        cyc(1'b1, 1'b0, dma_flag_pkg::CLEAR_OFS, 32'h100, 9'h040);
        rd(dma_flag_pkg::STATUS_OFS, 32'h300);
        wr(dma_flag_pkg::CLEAR_OFS, 32'h100);
        rd(dma_flag_pkg::STATUS_OFS, 32'h0);
        $display("t_count_one done");
    endtask

    // Interrupt causes pile up while masked; the read drains them.
    task automatic t_irq;
        rd(dma_flag_pkg::IRQ_STAT_OFS, 32'hFFF);
        wr(dma_flag_pkg::IRQ_MASK_OFS, 32'h2);
        rd(dma_flag_pkg::IRQ_MASK_OFS, 32'h2);
        cyc(1'b0, 1'b0, 8'h00, 32'h0, 9'h002);
        repeat (2) cyc(1'b0, 1'b0, 8'h00, 32'h0, 9'h000);
        #1 `CHK(irq, 1'b0)
        cyc(1'b0, 1'b0, 8'h00, 32'h0, 9'h001);
        repeat (2) cyc(1'b0, 1'b0, 8'h00, 32'h0, 9'h000);
        #1 `CHK(irq, 1'b1)
        rd(dma_flag_pkg::IRQ_STAT_OFS, 32'h7);
        cyc(1'b0, 1'b0, 8'h00, 32'h0, 9'h000);
        #1 `CHK(irq, 1'b0)
        rd(dma_flag_pkg::CLEAR_OFS, 32'h0);
        rd(8'h10, 32'h0);
        $display("t_irq done");
    endtask

    // A low enable freezes the bank and drops what arrives; a mid-run reset wipes it.
    task automatic t_freeze;
        @(posedge clock) clk_en <= 1'b0;
        cyc(1'b0, 1'b0, 8'h00, 32'h0, 9'h020);
        cyc(1'b1, 1'b0, dma_flag_pkg::CLEAR_OFS, 32'h1, 9'h000);
        cyc(1'b0, 1'b0, 8'h00, 32'h0, 9'h000);
        clk_en <= 1'b1;
        rd(dma_flag_pkg::STATUS_OFS, 32'h7);
        @(posedge clock) sys_rst <= 1'b1;
        repeat (2) @(posedge clock);
        sys_rst <= 1'b0;
        rd(dma_flag_pkg::STATUS_OFS, 32'h0);
        rd(dma_flag_pkg::IRQ_MASK_OFS, 32'h0);
        $display("t_freeze done");
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask

    // Reset, then the scenarios in order.
    initial begin
        sys_rst = 1'b1;
        clk_en = 1'b1;
        bus_wr_en = 1'b0;
        bus_rd_en = 1'b0;
        bus_addr = 8'h00;
        bus_wr_data = 32'h0;
        ch_events = 9'h000;
        counts = {3{16'h0005}};
        repeat (3) @(posedge clock);
        sys_rst <= 1'b0;
        rd(dma_flag_pkg::STATUS_OFS, 32'h0);
        rd(dma_flag_pkg::IRQ_MASK_OFS, 32'h0);
        t_events();
        t_count_one();
        t_irq();
        t_freeze();
        end_of_test();
    end
endmodule

bind dma_event_status_flags dma_event_status_flags_sva sva_u (.clock(clock), .sys_rst(sys_rst),
    .clk_en(clk_en), .bus_addr(bus_addr), .bus_wr_data(bus_wr_data), .bus_wr_en(bus_wr_en),
    .bus_rd_en(bus_rd_en), .ch_events(ch_events),
    .remaining_transfer_count(remaining_transfer_count), .bus_rd_data(bus_rd_data), .irq(irq));
